// >>> core_debug_breakpoint_unit.sv
// tile debug state, scratch and breakpoint/watchpoint logic
// Functional notes
// - oscillator counts are 16 bits, upper bits zero, never reset
// - saved status captured at index 0x10 on debugger entry
// - saved program counter captured at 0x11, debugger writable
// - saved stack pointer captured at 0x12, debugger writable
// - core-select operand holds 8-bit logical core number
// - register-select operand holds 5-bit register number
// - 3-bit cause resets to 0; codes host, call, ibp, data, resource
// - breakpoint/watchpoint index recorded, lowest wins when several hit
// - causing core number recorded, otherwise zero
// - payload gets effective address or resource id on watchpoint hit
// - eight scratch words shared with tile configuration access
// - debugger and debug code exchange messages through scratch
// - enabled instruction breakpoint fires on program counter match
// - per-core enable mask per breakpoint, reset zero
// - invert bit makes breakpoint fire on mismatch
// - control bit zero enables breakpoint, reset zero
// - four first-address data watch registers
// - four second-address data watch registers
// - data watch inclusive range, or outside it when inverted
// - resource watch masked id equals value, or differs inverted
`timescale 1ns/1ps
`default_nettype none
module core_debug_breakpoint_unit
   import core_debug_pkg::*;
(
   input  wire logic                    i_core_clk,
   input  wire logic                    i_resetn,
   input  wire logic                    i_ps_write,
   input  wire logic                    i_ps_read,
   input  wire logic [7:0]              i_ps_index,
   input  wire logic [31:0]             i_ps_wdata,
   output logic      [31:0]             o_ps_rdata,
   output logic                         o_ps_rvalid,
   input  wire logic                    i_cfg_write,
   input  wire logic                    i_cfg_read,
   input  wire logic [SCRATCH_IDX_W-1:0] i_cfg_index,
   input  wire logic [31:0]             i_cfg_wdata,
   output logic      [31:0]             o_cfg_rdata,
   output logic                         o_cfg_rvalid,
   input  wire logic [OSC_W-1:0]        i_cell_osc_count,
   input  wire logic [OSC_W-1:0]        i_wire_osc_count,
   input  wire logic [31:0]             i_saved_status_value,
   input  wire logic [31:0]             i_saved_program_counter,
   input  wire logic [31:0]             i_saved_stack_pointer,
   input  wire logic                    i_debug_return,
   output logic                         o_debug_mode,
   output logic                         o_debug_irq,
   output logic      [NUM_CORES-1:0]    o_core_stop,
   output logic      [CORE_SEL_W-1:0]   o_read_core_select,
   output logic      [REG_SEL_W-1:0]    o_read_reg_select,
   input  wire logic                    i_host_request,
   input  wire logic                    i_debug_call_instruction_valid,
   input  wire logic [CORE_IDX_W-1:0]   i_debug_call_instruction_core,
   input  wire logic                    i_pc_valid,
   input  wire logic [31:0]             i_pc,
   input  wire logic [CORE_IDX_W-1:0]   i_pc_core,
   input  wire logic                    i_mem_valid,
   input  wire logic                    i_mem_store,
   input  wire logic [31:0]             i_mem_addr,
   input  wire logic [CORE_IDX_W-1:0]   i_mem_core,
   input  wire logic [NUM_POINTS-1:0]   i_dw_enable,
   input  wire logic [NUM_POINTS-1:0]   i_dw_invert,
   input  wire logic [NUM_POINTS-1:0]   i_dw_on_load,
   input  wire logic                    i_res_valid,
   input  wire logic [31:0]             i_res_id,
   input  wire logic [CORE_IDX_W-1:0]   i_res_core,
   input  wire logic [NUM_POINTS-1:0]   i_rw_enable,
   input  wire logic [NUM_POINTS-1:0]   i_rw_invert,
   input  wire logic [NUM_POINTS-1:0][31:0] i_rw_mask,
   input  wire logic [NUM_POINTS-1:0][31:0] i_rw_value
);
   // -------------------------------------------------------------
   // storage
   // -------------------------------------------------------------
   dbg_state_e                state;
   dbg_state_e                next_state;
   logic [OSC_W-1:0]          cell_sync1;
   logic [OSC_W-1:0]          cell_sync2;
   logic [OSC_W-1:0]          wire_sync1;
   logic [OSC_W-1:0]          wire_sync2;
   logic [31:0]               saved_status;
   logic [31:0]               saved_pc;
   logic [31:0]               saved_sp;
   logic [CORE_SEL_W-1:0]     core_select;
   logic [REG_SEL_W-1:0]      reg_select;
   logic [CAUSE_W-1:0]        cause_code;
   logic [CORE_NUM_W-1:0]     cause_core;
   logic [POINT_IDX_W-1:0]    cause_point;
   logic [31:0]               payload;
   logic [NUM_CORES-1:0]      stop_mask;
   logic [31:0]               scratch [NUM_SCRATCH];
   logic [31:0]               ibp_addr [NUM_POINTS];
   logic [NUM_POINTS-1:0]     ibp_enable;
   logic [NUM_POINTS-1:0]     ibp_invert;
   logic [NUM_CORES-1:0]      ibp_cores [NUM_POINTS];
   logic [31:0]               dw_first [NUM_POINTS];
   logic [31:0]               dw_second [NUM_POINTS];
   // -------------------------------------------------------------
   // write decode
   // -------------------------------------------------------------
   wire                        ps_wr        = i_ps_write && (state == st_debug);
   wire [1:0]                  pt_sel       = i_ps_index[1:0];
   wire [SCRATCH_IDX_W-1:0]    scr_sel      = i_ps_index[2:0];
   wire                        wr_pc        = ps_wr && (i_ps_index == IDX_SAVED_PC);
   wire                        wr_sp        = ps_wr && (i_ps_index == IDX_SAVED_SP);
   wire                        wr_core_sel  = ps_wr && (i_ps_index == IDX_CORE_SEL);
   wire                        wr_reg_sel   = ps_wr && (i_ps_index == IDX_REG_SEL);
   wire                        wr_cause     = ps_wr && (i_ps_index == IDX_CAUSE);
   wire                        wr_payload   = ps_wr && (i_ps_index == IDX_PAYLOAD);
   wire                        wr_stop      = ps_wr && (i_ps_index == IDX_STOP);
   wire                        hit_scratch  = (i_ps_index[7:3] == IDX_SCRATCH_BASE[7:3]);
   wire                        hit_ibp_addr = (i_ps_index[7:2] == IDX_IBP_ADDR_BASE[7:2]);
   wire                        hit_ibp_ctrl = (i_ps_index[7:2] == IDX_IBP_CTRL_BASE[7:2]);
   wire                        hit_dw_first = (i_ps_index[7:2] == IDX_DW_FIRST_BASE[7:2]);
   wire                        hit_dw_sec   = (i_ps_index[7:2] == IDX_DW_SECOND_BASE[7:2]);
   wire                        wr_scratch   = ps_wr && hit_scratch;
   wire                        wr_ibp_addr  = ps_wr && hit_ibp_addr;
   wire                        wr_ibp_ctrl  = ps_wr && hit_ibp_ctrl;
   wire                        wr_dw_first  = ps_wr && hit_dw_first;
   wire                        wr_dw_sec    = ps_wr && hit_dw_sec;
   // -------------------------------------------------------------
   // trigger detection
   // -------------------------------------------------------------
   logic [NUM_POINTS-1:0]     ibp_hit;
   logic [NUM_POINTS-1:0]     dw_hit;
   logic [NUM_POINTS-1:0]     rw_hit;
   genvar g;
   generate
      for (g = 0; g < NUM_POINTS; g++) begin : g_points
         wire pc_equal  = (i_pc == ibp_addr[g]);
         wire in_range  = (i_mem_addr >= dw_first[g]) && (i_mem_addr <= dw_second[g]);
         wire out_range = (i_mem_addr < dw_first[g]) || (i_mem_addr > dw_second[g]);
         wire res_equal = ((i_res_id & i_rw_mask[g]) == i_rw_value[g]);
         wire mem_kind  = i_mem_store || i_dw_on_load[g];
         assign ibp_hit[g] = i_pc_valid && ibp_enable[g] && ibp_cores[g][i_pc_core]
                             && (ibp_invert[g] ? !pc_equal : pc_equal);
         assign dw_hit[g]  = i_mem_valid && i_dw_enable[g] && mem_kind
                             && (i_dw_invert[g] ? out_range : in_range);
         assign rw_hit[g]  = i_res_valid && i_rw_enable[g]
                             && (i_rw_invert[g] ? !res_equal : res_equal);
      end
   endgenerate
   logic [POINT_IDX_W-1:0]    ibp_low;
   logic [POINT_IDX_W-1:0]    dw_low;
   logic [POINT_IDX_W-1:0]    rw_low;
   always_comb begin
      ibp_low = '0;
      dw_low  = '0;
      rw_low  = '0;
      for (int i = NUM_POINTS - 1; i >= 0; i--) begin
         if (ibp_hit[i]) begin
            ibp_low = POINT_IDX_W'(i);
         end
         if (dw_hit[i]) begin
            dw_low = POINT_IDX_W'(i);
         end
         if (rw_hit[i]) begin
            rw_low = POINT_IDX_W'(i);
         end
      end
   end

   // -------------------------------------------------------------
   // cause selection, host first then call, ibp, data, resource
   // -------------------------------------------------------------
   localparam logic [CORE_NUM_W-CORE_IDX_W-1:0] CORE_PAD = '0;
   logic [CAUSE_W-1:0]        next_code;
   logic [CORE_NUM_W-1:0]     next_core;
   logic [POINT_IDX_W-1:0]    next_point;
   logic [31:0]               next_payload;
   always_comb begin
      next_code    = CAUSE_NONE;
      next_core    = '0;
      next_point   = '0;
      next_payload = payload;
      if (i_host_request) begin
         next_code = CAUSE_HOST;
      end else if (i_debug_call_instruction_valid) begin
         next_code = CAUSE_DEBUG_CALL_INSTRUCTION;
         next_core = {CORE_PAD, i_debug_call_instruction_core};
      end else if (|ibp_hit) begin
         next_code  = CAUSE_IBP;
         next_core  = {CORE_PAD, i_pc_core};
         next_point = ibp_low;
      end else if (|dw_hit) begin
         next_code    = CAUSE_DWATCH;
         next_core    = {CORE_PAD, i_mem_core};
         next_point   = dw_low;
         next_payload = i_mem_addr;
      end else if (|rw_hit) begin
         next_code    = CAUSE_RWATCH;
         next_core    = {CORE_PAD, i_res_core};
         next_point   = rw_low;
         next_payload = i_res_id;
      end
   end

   wire take_irq = (state == st_run) && (next_code != CAUSE_NONE);

   // -------------------------------------------------------------
   // debug mode state
   // -------------------------------------------------------------
   always_comb begin
      case (state)
         st_run:   next_state = take_irq ? st_debug : st_run;
         st_debug: next_state = i_debug_return ? st_run : st_debug;
         default:  next_state = st_run;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         state       <= st_run;
         o_debug_irq <= 1'b0;
      end else begin
         state       <= next_state;
         o_debug_irq <= take_irq;
      end
   end

   // -------------------------------------------------------------
   // oscillator count synchronisers, kept across reset
   // -------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      cell_sync1 <= i_cell_osc_count;
      cell_sync2 <= cell_sync1;
      wire_sync1 <= i_wire_osc_count;
      wire_sync2 <= wire_sync1;
   end

   // -------------------------------------------------------------
   // captured context and interrupt record
   // -------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         saved_status <= '0;
         saved_pc     <= '0;
         saved_sp     <= '0;
         cause_code   <= CAUSE_NONE;
         cause_core   <= '0;
         cause_point  <= '0;
         payload      <= '0;
      end else if (take_irq) begin
         saved_status <= i_saved_status_value;
         saved_pc     <= i_saved_program_counter;
         saved_sp     <= i_saved_stack_pointer;
         cause_code   <= next_code;
         cause_core   <= next_core;
         cause_point  <= next_point;
         payload      <= next_payload;
      end else begin
         if (wr_pc) begin
            saved_pc <= i_ps_wdata;
         end
         if (wr_sp) begin
            saved_sp <= i_ps_wdata;
         end
         if (wr_cause) begin
            cause_code  <= i_ps_wdata[CAUSE_LSB +: CAUSE_W];
            cause_core  <= i_ps_wdata[CORE_NUM_LSB +: CORE_NUM_W];
            cause_point <= i_ps_wdata[POINT_LSB +: POINT_IDX_W];
         end
         if (wr_payload) begin
            payload <= i_ps_wdata;
         end
      end
   end

   // -------------------------------------------------------------
   // operands, stop mask and point registers
   // -------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         core_select <= '0;
         reg_select  <= '0;
         stop_mask   <= '0;
         ibp_enable  <= '0;
         ibp_invert  <= '0;
         for (int i = 0; i < NUM_POINTS; i++) begin
            ibp_addr[i]  <= '0;
            ibp_cores[i] <= '0;
            dw_first[i]  <= '0;
            dw_second[i] <= '0;
         end
      end else begin
         if (wr_core_sel) begin
            core_select <= i_ps_wdata[CORE_SEL_W-1:0];
         end
         if (wr_reg_sel) begin
            reg_select <= i_ps_wdata[REG_SEL_W-1:0];
         end
         if (wr_stop) begin
            stop_mask <= i_ps_wdata[NUM_CORES-1:0];
         end
         if (wr_ibp_addr) begin
            ibp_addr[pt_sel] <= i_ps_wdata;
         end
         if (wr_ibp_ctrl) begin
            ibp_enable[pt_sel] <= i_ps_wdata[CTRL_ENABLE];
            ibp_invert[pt_sel] <= i_ps_wdata[CTRL_INVERT];
            ibp_cores[pt_sel]  <= i_ps_wdata[CTRL_CORE_LSB +: NUM_CORES];
         end
         if (wr_dw_first) begin
            dw_first[pt_sel] <= i_ps_wdata;
         end
         if (wr_dw_sec) begin
            dw_second[pt_sel] <= i_ps_wdata;
         end
      end
   end

   // -------------------------------------------------------------
   // shared scratch, status port wins a same-word collision
   // -------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         for (int i = 0; i < NUM_SCRATCH; i++) begin
            scratch[i] <= '0;
         end
      end else begin
         if (i_cfg_write) begin
            scratch[i_cfg_index] <= i_cfg_wdata;
         end
         if (wr_scratch) begin
            scratch[scr_sel] <= i_ps_wdata;
         end
      end
   end

   // -------------------------------------------------------------
   // read mux
   // -------------------------------------------------------------
   localparam logic [31-OSC_W:0] OSC_PAD = '0;
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = '0;
      if (hit_scratch) begin
         next_rdata = scratch[scr_sel];
      end else if (hit_ibp_addr) begin
         next_rdata = ibp_addr[pt_sel];
      end else if (hit_ibp_ctrl) begin
         next_rdata[CTRL_ENABLE]                  = ibp_enable[pt_sel];
         next_rdata[CTRL_INVERT]                  = ibp_invert[pt_sel];
         next_rdata[CTRL_CORE_LSB +: NUM_CORES]   = ibp_cores[pt_sel];
      end else if (hit_dw_first) begin
         next_rdata = dw_first[pt_sel];
      end else if (hit_dw_sec) begin
         next_rdata = dw_second[pt_sel];
      end else begin
         case (i_ps_index)
            IDX_CELL_OSC:     next_rdata = {OSC_PAD, cell_sync2};
            IDX_WIRE_OSC:     next_rdata = {OSC_PAD, wire_sync2};
            IDX_SAVED_STATUS: next_rdata = saved_status;
            IDX_SAVED_PC:     next_rdata = saved_pc;
            IDX_SAVED_SP:     next_rdata = saved_sp;
            IDX_CORE_SEL:     next_rdata[CORE_SEL_W-1:0] = core_select;
            IDX_REG_SEL:      next_rdata[REG_SEL_W-1:0] = reg_select;
            IDX_CAUSE: begin
               next_rdata[CAUSE_LSB +: CAUSE_W]        = cause_code;
               next_rdata[CORE_NUM_LSB +: CORE_NUM_W]  = cause_core;
               next_rdata[POINT_LSB +: POINT_IDX_W]    = cause_point;
            end
            IDX_PAYLOAD:      next_rdata = payload;
            IDX_STOP:         next_rdata[NUM_CORES-1:0] = stop_mask;
            default:          next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         o_ps_rdata   <= '0;
         o_ps_rvalid  <= 1'b0;
         o_cfg_rdata  <= '0;
         o_cfg_rvalid <= 1'b0;
      end else begin
         o_ps_rvalid  <= i_ps_read;
         o_cfg_rvalid <= i_cfg_read;
         if (i_ps_read) begin
            o_ps_rdata <= next_rdata;
         end
         if (i_cfg_read) begin
            o_cfg_rdata <= scratch[i_cfg_index];
         end
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign o_debug_mode       = (state == st_debug);
   assign o_core_stop        = (state == st_run) ? stop_mask : '0;
   assign o_read_core_select = core_select;
   assign o_read_reg_select  = reg_select;
endmodule : core_debug_breakpoint_unit
`default_nettype wire

// >>> core_debug_breakpoint_unit_tb_top.sv
// self-checking bench for the debug unit
`timescale 1ns/1ps
`default_nettype none
module core_debug_breakpoint_unit_tb_top;
   logic i_core_clk, i_resetn, i_ps_write, i_ps_read, i_cfg_write, i_cfg_read, i_debug_return, go;
   logic i_host_request, i_debug_call_instruction_valid, i_pc_valid, i_mem_valid, i_mem_store, i_res_valid;
   logic o_ps_rvalid, o_cfg_rvalid, o_debug_mode, o_debug_irq;
   logic [7:0] i_ps_index, o_core_stop, o_read_core_select;
   logic [4:0] o_read_reg_select;
   logic [2:0] i_cfg_index, i_debug_call_instruction_core, i_pc_core, i_mem_core, i_res_core, pc_core;
   logic [15:0] i_cell_osc_count, i_wire_osc_count;
   logic [31:0] i_ps_wdata, o_ps_rdata, i_cfg_wdata, o_cfg_rdata, i_pc, i_mem_addr, i_res_id, pc_addr;
   logic [31:0] i_saved_status_value, i_saved_program_counter, i_saved_stack_pointer;
   logic [3:0] i_dw_enable, i_dw_invert, i_dw_on_load, i_rw_enable, i_rw_invert;
   logic [3:0][31:0] i_rw_mask, i_rw_value;
   int miscompares = 0;
   int samples_checked = 0;
   core_debug_breakpoint_unit u_core_debug_breakpoint_unit (.*);
   core_pipe_model u_core_pipe_model (.i_core_clk(i_core_clk), .i_go(go), .i_addr(pc_addr), .i_core(pc_core),
      .o_pc_valid(i_pc_valid), .o_pc(i_pc), .o_pc_core(i_pc_core));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic c, input logic [7:0] idx, input logic [31:0] d);
      @(negedge i_core_clk);
      {i_cfg_write, i_ps_write, i_ps_index, i_cfg_index, i_ps_wdata, i_cfg_wdata} = {c, !c, idx, idx[2:0], d, d};
      @(negedge i_core_clk);
      {i_cfg_write, i_ps_write} = 2'b00;
   endtask : wr
   task automatic rd(input logic c, input logic [7:0] idx, input logic [31:0] exp, input string nm);
      @(negedge i_core_clk);
      {i_cfg_read, i_ps_read, i_ps_index, i_cfg_index} = {c, !c, idx, idx[2:0]};
      @(negedge i_core_clk);
      {i_cfg_read, i_ps_read} = 2'b00;
      chk(nm, c ? o_cfg_rdata : o_ps_rdata, exp);
   endtask : rd
   task automatic took(input logic e, input logic [31:0] cause, input string nm);
      @(negedge i_core_clk);
      {i_host_request, i_debug_call_instruction_valid, i_mem_valid, i_res_valid} = 4'h0;
      chk(nm, {31'h0, o_debug_irq}, {31'h0, e});
      if (e) rd(0, 8'h15, cause, nm);
   endtask : took
   task automatic pc(input logic [31:0] a, input logic [2:0] k, input logic e, input logic [31:0] cause);
      {pc_addr, pc_core, go} <= {a, k, 1'b1};
      @(negedge i_core_clk);
      go <= 1'b0;
      took(e, cause, "pc");
   endtask : pc
   task automatic leave;
      @(negedge i_core_clk);
      i_debug_return = 1'b1;
      @(negedge i_core_clk);
      i_debug_return = 1'b0;
      chk("mode", {31'h0, o_debug_mode}, 32'h0);
      chk("stop", {24'h0, o_core_stop}, 32'hA5);
   endtask : leave
   task automatic stop_test;
      if (miscompares == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : stop_test
   initial begin
      i_core_clk = 1'b0;
      forever #10 i_core_clk = ~i_core_clk;
   end
   initial begin
      #100000;
      miscompares++;
      stop_test;
   end
   initial begin
      {i_resetn, i_ps_write, i_ps_read, i_cfg_write, i_cfg_read, i_debug_return, i_host_request, go} = '0;
      {i_debug_call_instruction_valid, i_mem_valid, i_mem_store, i_res_valid, i_ps_index, i_cfg_index, i_debug_call_instruction_core} = '0;
      {i_mem_core, i_res_core, pc_core, pc_addr, i_ps_wdata, i_cfg_wdata, i_mem_addr, i_res_id} = '0;
      {i_dw_enable, i_dw_invert, i_dw_on_load, i_rw_enable, i_rw_invert, i_rw_mask, i_rw_value} = '0;
      {i_cell_osc_count, i_wire_osc_count} = {16'hA5C3, 16'h3C5A};
      {i_saved_status_value, i_saved_program_counter, i_saved_stack_pointer} = {32'h5A10, 32'h4011, 32'h1F12};
      repeat (12) @(posedge i_core_clk);
      @(negedge i_core_clk);
      i_resetn = 1'b1;
      rd(0, 8'h15, 32'h0, "cause_rst");
      rd(0, 8'h41, 32'h0, "ctrl_rst");
      rd(0, 8'h09, 32'hA5C3, "osc");
      rd(0, 8'h0A, 32'h3C5A, "osc_w");
      wr(0, 8'h30, 32'h1234);
      rd(0, 8'h30, 32'h0, "run_wr");
      i_host_request = 1'b1;
      took(1, 32'h1, "host");
      {i_saved_status_value, i_saved_program_counter, i_saved_stack_pointer} = '1;
      rd(0, 8'h10, 32'h5A10, "sv_st");
      rd(0, 8'h11, 32'h4011, "sv_pc");
      rd(0, 8'h12, 32'h1F12, "sv_sp");
      wr(0, 8'h13, 32'hFFFFFFFF);
      rd(0, 8'h13, 32'hFF, "core_sel");
      chk("core_out", {24'h0, o_read_core_select}, 32'hFF);
      wr(0, 8'h14, 32'hFFFFFFFF);
      rd(0, 8'h14, 32'h1F, "reg_sel");
      chk("reg_out", {27'h0, o_read_reg_select}, 32'h1F);
      wr(0, 8'h27, 32'hCAFE0007);
      rd(1, 8'h27, 32'hCAFE0007, "scr_cfg");
      wr(1, 8'h20, 32'hBEEF0000);
      rd(0, 8'h20, 32'hBEEF0000, "scr_ps");
      wr(0, 8'h18, 32'h1A5);
      leave;
      {i_debug_call_instruction_valid, i_debug_call_instruction_core} = {1'b1, 3'h6};
      took(1, 32'h602, "debug_call_instruction");
      for (int i = 0; i < 3; i++) wr(0, 8'(8'h30 + i), 32'h100);
      wr(0, 8'h40, 32'h40001);
      wr(0, 8'h41, 32'h80001);
      wr(0, 8'h42, 32'h80001);
      leave;
      pc(32'h100, 3'h3, 1, 32'h10303);
      wr(0, 8'h30, 32'h200);
      wr(0, 8'h40, 32'hFF0003);
      wr(0, 8'h51, 32'h1000);
      wr(0, 8'h61, 32'h10FF);
      leave;
      pc(32'h200, 3'h5, 0, 32'h0);
      pc(32'h204, 3'h5, 1, 32'h503);
      leave;
      {i_dw_enable, i_mem_store, i_mem_core, i_mem_addr, i_mem_valid} = {4'h2, 1'b1, 3'h2, 32'h1100, 1'b1};
      took(0, 32'h0, "dw_out");
      @(negedge i_core_clk);
      {i_mem_addr, i_mem_valid} = {32'h10FF, 1'b1};
      took(1, 32'h10204, "dw_in");
      rd(0, 8'h16, 32'h10FF, "dw_data");
      leave;
      {i_dw_enable, i_rw_enable, i_rw_mask[3], i_rw_value[3]} = {4'h0, 4'h8, 32'hFFFF0000, 32'hABCD0000};
      {i_res_id, i_res_valid} = {32'hABCD1234, 1'b1};
      took(1, 32'h30005, "rw_hit");
      rd(0, 8'h16, 32'hABCD1234, "rw_data");
      leave;
      {i_rw_enable, i_dw_enable, i_dw_invert, i_dw_on_load, i_mem_store} = {4'h0, 4'h2, 4'h2, 4'h2, 1'b0};
      {i_mem_addr, i_mem_valid} = {32'h0FFF, 1'b1};
      took(1, 32'h10204, "dw_inv_ld");
      rd(0, 8'h16, 32'h0FFF, "dw_inv_data");
      leave;
      {i_dw_enable, i_rw_enable, i_rw_invert, i_res_id, i_res_valid} = {4'h0, 4'h8, 4'h8, 32'h1234, 1'b1};
      took(1, 32'h30005, "rw_inv");
      stop_test;
   end
endmodule : core_debug_breakpoint_unit_tb_top
bind core_debug_breakpoint_unit core_debug_chk u_core_debug_chk (.*);
`default_nettype wire

// >>> core_debug_chk_assertions.sv
// port checks for the debug unit
`timescale 1ns/1ps
`default_nettype none
module core_debug_chk (
   input wire logic        i_core_clk, i_resetn, i_cfg_read, i_host_request, i_debug_call_instruction_valid, i_debug_return,
   input wire logic        i_ps_read, o_ps_rvalid, o_cfg_rvalid, o_debug_mode, o_debug_irq,
   input wire logic [7:0]  i_ps_index, o_core_stop,
   input wire logic [31:0] o_ps_rdata
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   chk_osc_upper_zero: assert property (i_ps_read && i_ps_index == 8'h09 |=> o_ps_rdata[31:16] == 16'h0) else $error("osc");
   chk_cfg_read_answer: assert property (i_cfg_read |=> o_cfg_rvalid) else $error("cfg read");
   chk_ps_read_answer: assert property (o_ps_rvalid == $past(i_ps_read)) else $error("ps read");
   chk_host_take: assert property (!o_debug_mode && i_host_request |=> o_debug_irq && o_debug_mode) else $error("host");
   chk_call_take: assert property (!o_debug_mode && i_debug_call_instruction_valid |=> o_debug_irq) else $error("call");
   chk_irq_one_pulse: assert property (o_debug_irq |=> !o_debug_irq) else $error("irq pulse");
   chk_irq_with_entry: assert property (o_debug_irq == $rose(o_debug_mode)) else $error("irq entry");
   chk_stop_off_debug: assert property (o_debug_mode |-> o_core_stop == 8'h00) else $error("stop");
   chk_debug_holds: assert property (o_debug_mode && !i_debug_return |=> o_debug_mode) else $error("hold");
   chk_return_leaves: assert property (o_debug_mode && i_debug_return |=> !o_debug_mode) else $error("leave");
endmodule : core_debug_chk
`default_nettype wire

// >>> core_debug_pkg.sv
// constants for the tile debug state and breakpoint unit
package core_debug_pkg;
   // -------------------------------------------------------------
   // status register indices
   // -------------------------------------------------------------
   localparam logic [7:0] IDX_CELL_OSC        = 8'h09;
   localparam logic [7:0] IDX_WIRE_OSC        = 8'h0A;
   localparam logic [7:0] IDX_SAVED_STATUS    = 8'h10;
   localparam logic [7:0] IDX_SAVED_PC        = 8'h11;
   localparam logic [7:0] IDX_SAVED_SP        = 8'h12;
   localparam logic [7:0] IDX_CORE_SEL        = 8'h13;
   localparam logic [7:0] IDX_REG_SEL         = 8'h14;
   localparam logic [7:0] IDX_CAUSE           = 8'h15;
   localparam logic [7:0] IDX_PAYLOAD         = 8'h16;
   localparam logic [7:0] IDX_STOP            = 8'h18;
   localparam logic [7:0] IDX_SCRATCH_BASE    = 8'h20;
   localparam logic [7:0] IDX_IBP_ADDR_BASE   = 8'h30;
   localparam logic [7:0] IDX_IBP_CTRL_BASE   = 8'h40;
   localparam logic [7:0] IDX_DW_FIRST_BASE   = 8'h50;
   localparam logic [7:0] IDX_DW_SECOND_BASE  = 8'h60;
   // -------------------------------------------------------------
   // sizes and field layout
   // -------------------------------------------------------------
   localparam int NUM_CORES      = 8;
   localparam int NUM_POINTS     = 4;
   localparam int NUM_SCRATCH    = 8;
   localparam int CORE_IDX_W     = 3;
   localparam int POINT_IDX_W    = 2;
   localparam int SCRATCH_IDX_W  = 3;
   localparam int OSC_W          = 16;
   localparam int CORE_SEL_W     = 8;
   localparam int REG_SEL_W      = 5;
   localparam int CORE_NUM_W     = 8;
   localparam int CAUSE_W        = 3;
   localparam int CAUSE_LSB      = 0;
   localparam int CORE_NUM_LSB   = 8;
   localparam int POINT_LSB      = 16;
   localparam int CTRL_ENABLE    = 0;
   localparam int CTRL_INVERT    = 1;
   localparam int CTRL_CORE_LSB  = 16;
   // -------------------------------------------------------------
   // interrupt cause codes
   // -------------------------------------------------------------
   localparam logic [2:0] CAUSE_NONE   = 3'h0;
   localparam logic [2:0] CAUSE_HOST   = 3'h1;
   localparam logic [2:0] CAUSE_DEBUG_CALL_INSTRUCTION  = 3'h2;
   localparam logic [2:0] CAUSE_IBP    = 3'h3;
   localparam logic [2:0] CAUSE_DWATCH = 3'h4;
   localparam logic [2:0] CAUSE_RWATCH = 3'h5;
   // -------------------------------------------------------------
   // debug mode states
   // -------------------------------------------------------------
   typedef enum logic {
      st_run,
      st_debug
   } dbg_state_e;
endpackage : core_debug_pkg

// >>> core_pipe_model.sv
// core pipeline stand-in: drives the executing pc stream
`timescale 1ns/1ps
`default_nettype none
module core_pipe_model (
   input  wire logic        i_core_clk,
   input  wire logic        i_go,
   input  wire logic [31:0] i_addr,
   input  wire logic [2:0]  i_core,
   output logic             o_pc_valid,
   output logic [31:0]      o_pc,
   output logic [2:0]       o_pc_core
);
   initial {o_pc_valid, o_pc, o_pc_core} = '0;
   // idle cycles show an inverted pc so no stale match lingers
   always @(negedge i_core_clk) begin
      o_pc_valid <= i_go;
      o_pc       <= i_go ? i_addr : ~o_pc;
      o_pc_core  <= i_go ? i_core : ~o_pc_core;
   end
endmodule : core_pipe_model
`default_nettype wire
